// ---- src/fcoc_pkg.sv ----
// package of constants and types for the fail contact output control block
package fcoc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_POLICY = 8'h04;
    localparam logic [7:0] ADDR_FAULT = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    // ctrl fields
    localparam int CTRL_VARIANT_LSB = 0;
    localparam int CTRL_IMMEDIATE = 2;
    localparam int CTRL_DEBUG = 3;
    localparam int CTRL_SW_FAIL = 4;
    localparam int CTRL_MOD_SMALL = 5;
    // fault register fields (software also reports faults here)
    localparam int FLT_MAJOR = 0;
    localparam int FLT_MODERATE = 1;
    localparam int FLT_MINOR = 2;
    localparam int FLT_SUPPLY = 3;
    localparam int FLT_WDT = 4;
    localparam int FLT_PROG_UNIT = 5;
    localparam int FLT_ERR_STOP = 6;
    // interrupt bits, same order as fault fields
    localparam int IRQ_W = 7;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] POLICY_RESET = 32'h0000_0000; // all groups hold
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // module point count limit for group reset on a fail stop (major, watchdog, software, program unit fail or error stop)
    localparam int RESET_POINT_LIMIT = 32;
    localparam int GROUP_POINTS = 8;
    // cpu variants
    typedef enum logic [1:0] {
        FCOC_VAR_SEQ = 2'b00,
        FCOC_VAR_OSFREE = 2'b01,
        FCOC_VAR_STDLANG = 2'b10
    } fcoc_variant_t;
    // severity state machine, one-hot
    typedef enum logic [3:0] {
        FCOC_ST_RUN = 4'b0001,
        FCOC_ST_MINOR = 4'b0010,
        FCOC_ST_MODER = 4'b0100,
        FCOC_ST_STOP = 4'b1000
    } fcoc_state_t;
endpackage : fcoc_pkg

// ---- src/fcoc_top.sv ----
// fail contact output control: severity, lamps, fail contacts, output hold/reset policy
`timescale 1ns/1ps
// overview of the block
// fault causes arrive from two places: asynchronous event pins from the cpu core,
// and a software fault register that firmware writes over the register bus.
// the pins pass two flip-flops first, so a pin change needs four edges to reach
// the lamps and contacts: two for the synchroniser, one for the severity state,
// and one for the output registers.
// severity is a small one-hot machine: run, minor, moderate and stop (major).
// it only ever climbs. a latched failure is cleared by hreset only, because a
// controller that has stopped must not restart on its own when a cause drops.
// supply abnormality and the fail stops (watchdog, fail program unit, error stop)
// are latched in their own flags beside the state, since they combine with any
// severity and change the contacts independently of it, supply only with immediate detection.
// fail contact a and b are always complementary; a shorted means failure.
// in reset both contacts show the unpowered pattern, a shorted and b open, so
// external equipment sees a failure until the block is running.
// group_reset has one bit per 8-point output group. apart from immediate supply detection, a group is only reset when
// a fail stop is active, its policy bit asks for reset and the module is small
// enough; otherwise the group holds. the moderate state on its own never resets.
// immediate supply detection resets every ordinary group regardless of policy.
// relay_reset stays low for good: the advanced relays always hold.
// outputs_run drops as soon as any stop or supply abnormality is latched.
// the interrupt status collects rising edges of every cause; software clears
// bits by writing ones, and a new edge in the same cycle wins over the clear.
// the bus slave answers without wait states and always with an okay response.
// limitation: hsize is not decoded, so byte and halfword writes touch the
// whole word; firmware must use word accesses only.
// limitation: the cpu variant field is stored for firmware only; all variants
// share the same hold-or-reset decode here.
// Notes on behaviour
// - reset outputs only if small module, policy reset (immediate supply detection resets every group regardless)
// - hold policy keeps outputs on major/moderate
// - major: ready lamp off, contact a short
// - moderate: error lamp, contact a open, hold
// - debug mode lights alarm lamp
// - supply fault: standard holds, immediate resets
// - watchdog: contact a short, group policy
// - software fail call: contact a short, policy
// - os-free policy per 8 points, default hold
// - std-language error stop or unit: fail
// - stop mode per 8 points, not relays
// - advanced relays always hold on failure
module fcoc_top
    import fcoc_pkg::*;
#(
    parameter int GROUPS = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // fault event pins from the cpu core, asynchronous
    input wire logic fault_major_pin,
    input wire logic fault_moderate_pin,
    input wire logic fault_minor_pin,
    input wire logic supply_abnormal_pin,
    input wire logic watchdog_timeout_pin,
    // lamps
    output logic ready_lamp,
    output logic error_lamp,
    output logic alarm_lamp,
    // fail contacts, 1 = shorted to common
    output logic fail_contact_a,
    output logic fail_contact_b,
    // per group: 1 = outputs forced to reset, for ordinary outputs; advanced relays use relay_reset
    output logic [GROUPS-1:0] group_reset,
    output logic relay_reset,
    // outputs continue to follow the program
    output logic outputs_run,
    // interrupt
    output logic irq
);
    // two-flop synchronisers for pins
    // the pins come from another clock domain, so nothing but the first
    // stage may read them; the first stage is free to go metastable
    // reset to zero: no cause is active while the block is held in reset
    logic [4:0] sync1, sync2;
    logic [4:0] next_sync1;
    always_comb begin
        next_sync1 = {watchdog_timeout_pin, supply_abnormal_pin, fault_minor_pin,
                      fault_moderate_pin, fault_major_pin};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end

    // registers
    // all registers are whole words; unused upper bits read back as written
    // for ctrl, policy and fault, which keeps the write path simple
    // the status register keeps only its low event bits
    logic [31:0] ctrl, policy, fault_sw, stat, mask;
    logic [31:0] next_ctrl, next_policy, next_fault_sw, next_stat, next_mask;
    // ahb data phase capture
    logic dp_valid, dp_write;
    logic [7:0] dp_addr;
    logic next_dp_valid, next_dp_write;
    logic [7:0] next_dp_addr;
    logic [31:0] next_hrdata;
    // latched fault state
    fcoc_state_t state, next_state;
    logic sup_seen, next_sup_seen;
    logic wdt_seen, next_wdt_seen;
    logic [6:0] cause, prev_cause;
    logic [6:0] events;

    // combined fault causes: pins plus software-reported bits
    // software bits are levels too, so a written fault stays active until
    // software writes it back to zero; the severity latch keeps it anyway
    // events are the rising edges, compared with the previous cycle
    always_comb begin
        cause[FLT_MAJOR] = sync2[0] | fault_sw[FLT_MAJOR];
        cause[FLT_MODERATE] = sync2[1] | fault_sw[FLT_MODERATE];
        cause[FLT_MINOR] = sync2[2] | fault_sw[FLT_MINOR];
        cause[FLT_SUPPLY] = sync2[3] | fault_sw[FLT_SUPPLY];
        cause[FLT_WDT] = sync2[4] | fault_sw[FLT_WDT];
        cause[FLT_PROG_UNIT] = fault_sw[FLT_PROG_UNIT];
        cause[FLT_ERR_STOP] = fault_sw[FLT_ERR_STOP];
        events = cause & ~prev_cause;
    end

    // bus slave and register next values
    // the address phase is captured when hsel, hready and a nonsequential or
    // sequential htrans meet at an edge; the write then lands with hwdata in
    // the following data phase
    // read data is fetched from the address phase so that it stands in hrdata
    // for the whole data phase
    always_comb begin
        next_dp_valid = hsel && hready && htrans[1];
        next_dp_write = hwrite;
        next_dp_addr = haddr;
        next_ctrl = ctrl;
        next_policy = policy;
        next_fault_sw = fault_sw;
        next_mask = mask;
        next_stat = stat;
        next_hrdata = 32'h0000_0000;
        if (dp_valid && dp_write) begin
            unique case (dp_addr)
                ADDR_CTRL: next_ctrl = hwdata;
                ADDR_POLICY: next_policy = hwdata;
                ADDR_FAULT: next_fault_sw = hwdata;
                ADDR_IRQ_MASK: next_mask = hwdata;
                ADDR_IRQ_STAT: next_stat = stat & ~hwdata;
                default: ;
            endcase
        end
        // set wins over a simultaneous write-one clear
        next_stat[IRQ_W-1:0] = next_stat[IRQ_W-1:0] | events;
        next_stat[31:IRQ_W] = '0;
        // read data presented in the data phase of a read
        if (next_dp_valid && !hwrite) begin
            unique case (haddr)
                ADDR_CTRL: next_hrdata = ctrl;
                ADDR_POLICY: next_hrdata = policy;
                ADDR_FAULT: next_hrdata = fault_sw;
                ADDR_STATE: next_hrdata = {22'h00_0000, sup_seen, wdt_seen, state, fail_contact_b, fail_contact_a,
                                           outputs_run, relay_reset};
                ADDR_IRQ_STAT: next_hrdata = stat;
                ADDR_IRQ_MASK: next_hrdata = mask;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // severity state: the worst active failure, latched until reset
    // major beats moderate beats minor when several arrive together
    // minor may still climb to moderate or stop, moderate only to stop
    // an illegal code falls to stop, the safe side for the contacts
    always_comb begin
        next_state = state;
        next_sup_seen = sup_seen | cause[FLT_SUPPLY];
        next_wdt_seen = wdt_seen | cause[FLT_WDT] | cause[FLT_PROG_UNIT] | cause[FLT_ERR_STOP];
        unique case (state)
            FCOC_ST_RUN, FCOC_ST_MINOR: begin
                if (cause[FLT_MAJOR]) next_state = FCOC_ST_STOP;
                else if (cause[FLT_MODERATE]) next_state = FCOC_ST_MODER;
                else if (cause[FLT_MINOR]) next_state = FCOC_ST_MINOR;
            end
            FCOC_ST_MODER: begin
                if (cause[FLT_MAJOR]) next_state = FCOC_ST_STOP;
            end
            FCOC_ST_STOP: ;
            default: next_state = FCOC_ST_STOP;
        endcase
    end

    // output decode
    logic n_ready, n_err, n_alm, n_fa, n_fb, n_relay, n_run;
    logic [GROUPS-1:0] n_grp;
    logic stop_fail, small_mod, imm;
    // all decodes are registered below, so the outputs never glitch
    // the variant field is not decoded: every variant shares this behaviour
    always_comb begin
        imm = ctrl[CTRL_IMMEDIATE];
        small_mod = ctrl[CTRL_MOD_SMALL] || (GROUPS * GROUP_POINTS <= RESET_POINT_LIMIT);
        // fail stops that drive contact a shorted and apply the group policy
        stop_fail = (state == FCOC_ST_STOP) || wdt_seen || ctrl[CTRL_SW_FAIL];
        n_ready = (state != FCOC_ST_STOP);
        n_err = (state == FCOC_ST_MODER);
        n_alm = (state == FCOC_ST_MINOR) || ctrl[CTRL_DEBUG];
        // normal: a open, b shorted; failure stops and immediate supply fault reverse it
        n_fa = stop_fail || (sup_seen && imm);
        n_fb = !n_fa;
        n_relay = 1'b0;
        n_run = (state == FCOC_ST_RUN || state == FCOC_ST_MINOR) && !stop_fail && !sup_seen;
    end
    // per 8-point group reset decision
    // one policy bit per group; policy bits above GROUPS are ignored
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        always_comb begin
            // moderate alone never resets; hold policy (0) holds unless an immediate supply fault is latched
            n_grp[g] = (stop_fail && policy[g] && small_mod) || (sup_seen && imm);
        end
    end

    // register everything
    // every top-level output leaves from a flip-flop of this process
    // the reset branch loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1; // zero-wait slave, ready even in reset
            hresp <= 1'b0; // always okay
            ctrl <= CTRL_RESET;
            policy <= POLICY_RESET;
            fault_sw <= 32'h0000_0000;
            stat <= 32'h0000_0000;
            mask <= MASK_RESET;
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            state <= FCOC_ST_RUN;
            sup_seen <= 1'b0;
            wdt_seen <= 1'b0;
            prev_cause <= 7'h00;
            ready_lamp <= 1'b0;
            error_lamp <= 1'b0;
            alarm_lamp <= 1'b0;
            fail_contact_a <= 1'b1; // powered-off state until running
            fail_contact_b <= 1'b0;
            group_reset <= '0;
            relay_reset <= 1'b0;
            outputs_run <= 1'b0;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl <= next_ctrl;
            policy <= next_policy;
            fault_sw <= next_fault_sw;
            stat <= next_stat;
            mask <= next_mask;
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
            state <= next_state;
            sup_seen <= next_sup_seen;
            wdt_seen <= next_wdt_seen;
            prev_cause <= cause;
            ready_lamp <= n_ready;
            error_lamp <= n_err;
            alarm_lamp <= n_alm;
            fail_contact_a <= n_fa;
            fail_contact_b <= n_fb;
            group_reset <= n_grp;
            relay_reset <= n_relay;
            outputs_run <= n_run;
            irq <= |(next_stat[IRQ_W-1:0] & next_mask[IRQ_W-1:0]);
        end
    end
    // assertions
    // they watch the registered outputs one edge after the decode inputs,
    // matching the single output register stage
    contacts_opposite_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 fail_contact_b == !fail_contact_a) else $error("fail contacts not complementary");
    major_lamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == FCOC_ST_STOP |=> !ready_lamp && fail_contact_a) else $error("major stop indication wrong");
    moder_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == FCOC_ST_MODER && !stop_fail && !sup_seen |=> error_lamp && !fail_contact_a && group_reset == '0)
        else $error("moderate failure indication wrong");
    hold_policy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        policy[0] == 1'b0 && !(sup_seen && imm) |=> !group_reset[0]) else $error("hold group was reset");
    reset_policy_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stop_fail && policy[0] && small_mod |=> group_reset[0]) else $error("reset group not reset");
    debug_alarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl[CTRL_DEBUG] |=> alarm_lamp) else $error("debug mode alarm lamp off");
    supply_imm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sup_seen && imm |=> fail_contact_a && group_reset == {GROUPS{1'b1}}) else $error("immediate supply wrong");
    supply_std_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sup_seen && !imm && !stop_fail |=> !fail_contact_a && group_reset == '0) else $error("standard supply wrong");
    wdt_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sync2[4]) |-> ##[1:3] fail_contact_a) else $error("watchdog did not short contact a");
    sw_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl[CTRL_SW_FAIL] |=> fail_contact_a) else $error("software fail not shown");
    relay_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 !relay_reset) else $error("advanced relays reset");
    minor_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == FCOC_ST_MINOR && !stop_fail && !sup_seen |=> alarm_lamp && outputs_run && fail_contact_b)
        else $error("minor failure indication wrong");
    stdlang_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_sw[FLT_ERR_STOP] |-> ##[1:2] fail_contact_a) else $error("error stop not shown");
    cover_major_c: cover property (@(posedge hclk) state == FCOC_ST_STOP);
    cover_moder_c: cover property (@(posedge hclk) state == FCOC_ST_MODER);
    cover_supply_c: cover property (@(posedge hclk) sup_seen && imm);
    run_normal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == FCOC_ST_RUN && !stop_fail && !sup_seen |=> ready_lamp && !fail_contact_a && outputs_run)
        else $error("normal operation indication wrong");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 irq == |(stat[IRQ_W-1:0] & mask[IRQ_W-1:0])) else $error("interrupt line wrong");
    cover_irq_c: cover property (@(posedge hclk) irq);
    cover_wdt_c: cover property (@(posedge hclk) wdt_seen && fail_contact_a);
endmodule : fcoc_top

// ---- testbench/fcoc_out_model.sv ----
// behavioural model of the output modules that sit behind the fail contact block
`timescale 1ns/1ps
module fcoc_out_model
    import fcoc_pkg::*;
#(
    parameter int GROUPS = 4
) (
    // clock
    input wire logic hclk,
    // stop-time control from the block
    input wire logic [GROUPS-1:0] group_reset,
    input wire logic relay_reset,
    input wire logic outputs_run,
    // program image in, module outputs out
    input wire logic [GROUPS*8-1:0] prog_data,
    output logic [GROUPS*8-1:0] out_state,
    output logic relay_out
);
    // outputs track the program while running; once stopped each group holds or clears
    always_ff @(posedge hclk) begin
        for (int g = 0; g < GROUPS; g++) begin
            if (outputs_run) begin
                out_state[g*GROUP_POINTS +: GROUP_POINTS] <= prog_data[g*GROUP_POINTS +: GROUP_POINTS];
            end else if (group_reset[g]) begin
                out_state[g*GROUP_POINTS +: GROUP_POINTS] <= '0;
            end
            // no else: a stopped group with hold policy keeps its last state
        end
        // advanced relays only ever hold, so relay_reset is deliberately ignored
        if (outputs_run) begin
            relay_out <= prog_data[0];
        end
    end
endmodule : fcoc_out_model

// ---- testbench/fail_contact_output_control_tb.sv ----
// self-checking bench for the fail contact output control block
`timescale 1ns/1ps
module fail_contact_output_control_tb
    import fcoc_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic hreadyout, hresp, ready_lamp, error_lamp, alarm_lamp, fail_contact_a, fail_contact_b;
    logic relay_reset, outputs_run, irq, relay_out;
    logic [4:0] pins = 5'b0_0000; // {watchdog, supply, minor, moderate, major}
    logic [3:0] group_reset;
    logic [31:0] prog_data = 32'hFFFF_FFFF, out_state;
    int errors = 0, checked = 0, cycles = 0;
    // 10 MHz clock
    always #50 hclk = ~hclk;
    fcoc_top #(.GROUPS(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_major_pin(pins[0]),
        .fault_moderate_pin(pins[1]), .fault_minor_pin(pins[2]), .supply_abnormal_pin(pins[3]),
        .watchdog_timeout_pin(pins[4]), .ready_lamp(ready_lamp), .error_lamp(error_lamp),
        .alarm_lamp(alarm_lamp), .fail_contact_a(fail_contact_a), .fail_contact_b(fail_contact_b),
        .group_reset(group_reset), .relay_reset(relay_reset), .outputs_run(outputs_run), .irq(irq));
    fcoc_out_model #(.GROUPS(4)) u_model (.hclk(hclk), .group_reset(group_reset), .relay_reset(relay_reset),
        .outputs_run(outputs_run), .prog_data(prog_data), .out_state(out_state), .relay_out(relay_out));
    // compare one value and count it
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // verdict, called from the end of the sequence or by the timeout
    task summarize();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // one single ahb-lite word transfer; entered just after a rising edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] data);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        data = hrdata;
    endtask : ahb
    // clear latched faults with a short reset; contacts must show the power-off state meanwhile
    task rst();
        hresetn <= 1'b0;
        pins <= 5'b0_0000;
        repeat (2) @(posedge hclk);
        chk("reset contacts", 32'h1, {fail_contact_b, fail_contact_a});
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : rst
    // reset, configure, raise a fault, wait out the sync latency and check contacts and groups
    task scen(input logic [31:0] ctrl, input logic [31:0] pol, input logic [4:0] p, input logic [31:0] flt,
              input logic exp_a, input logic [3:0] exp_gr);
        rst();
        ahb(1'b1, ADDR_CTRL, ctrl, rd);
        ahb(1'b1, ADDR_POLICY, pol, rd);
        ahb(1'b1, ADDR_FAULT, flt, rd);
        pins <= p;
        repeat (8) @(posedge hclk);
        chk("contacts", {30'h0, ~exp_a, exp_a}, {fail_contact_b, fail_contact_a});
        chk("group_reset", {28'h0, exp_gr}, group_reset);
        chk("relay_reset", 32'h0, relay_reset);
    endtask : scen
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge hclk);
        chk("power off contacts", 32'h1, {fail_contact_b, fail_contact_a});
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("run state", 32'hD, {ready_lamp, fail_contact_b, fail_contact_a, outputs_run});
        ahb(1'b0, ADDR_POLICY, 32'h0, rd);
        chk("policy default", POLICY_RESET, rd);
        chk("hresp okay", 32'h0, hresp);
        ahb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrl default", CTRL_RESET, rd);
        ahb(1'b0, ADDR_IRQ_MASK, 32'h0, rd);
        chk("mask default", MASK_RESET, rd);
        ahb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h1C, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        scen(32'h0000_0020, 32'h0, 5'b0_0001, 32'h0, 1'b1, 4'h0);
        scen(32'h0000_0020, 32'h5, 5'b0_0001, 32'h0, 1'b1, 4'h5);
        chk("major ready lamp", 32'h0, ready_lamp);
        prog_data <= 32'h0000_0000;
        repeat (2) @(posedge hclk);
        chk("held outputs", 32'hFF00_FF00, out_state);
        chk("relay held", 32'h1, relay_out);
        prog_data <= 32'hFFFF_FFFF;
        scen(32'h0000_0020, 32'hF, 5'b0_0010, 32'h0, 1'b0, 4'h0);
        chk("moderate error lamp", 32'h1, error_lamp);
        scen(32'h0, 32'hF, 5'b0_1000, 32'h0, 1'b0, 4'h0);
        scen(32'h0000_0004, 32'h0, 5'b0_1000, 32'h0, 1'b1, 4'hF);
        scen(32'h0, 32'h3, 5'b1_0000, 32'h0, 1'b1, 4'h3);
        scen(32'h0000_0011, 32'h6, 5'b0_0000, 32'h0, 1'b1, 4'h6);
        scen(32'h0000_0002, 32'h9, 5'b0_0000, 32'h20, 1'b1, 4'h9);
        scen(32'h0000_0002, 32'hA, 5'b0_0000, 32'h40, 1'b1, 4'hA);
        scen(32'h0000_0008, 32'h0, 5'b0_0000, 32'h0, 1'b0, 4'h0);
        chk("debug alarm", 32'h1, alarm_lamp);
        scen(32'h0, 32'hF, 5'b0_0100, 32'h0, 1'b0, 4'h0);
        chk("minor alarm run", 32'h3, {alarm_lamp, outputs_run});
        // interrupt: sticky status, mask changes the line, write-one clears it
        ahb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        chk("irq status", 32'h4, rd & 32'h4);
        chk("irq masked", 32'h0, irq);
        ahb(1'b1, ADDR_IRQ_MASK, 32'h7F, rd);
        repeat (2) @(posedge hclk);
        chk("mask effect", 32'h1, irq);
        ahb(1'b1, ADDR_IRQ_STAT, 32'h7F, rd);
        ahb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        chk("irq cleared", 32'h0, rd);
        repeat (2) @(posedge hclk);
        chk("irq line", 32'h0, irq);
        summarize();
    end
endmodule : fail_contact_output_control_tb
